// >>> rtl/serial_port_clock_generator.sv
// clock generation unit of the serial port with apb register access
`timescale 1ns/10ps
module serial_port_clock_generator (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic xck_in,
   output logic xck_out,
   output logic xck_oe,
   output logic tx_clk_en,
   output logic rx_clk_en,
   output logic rx_recovery_active,
   output logic sync_sample_en,
   output logic sync_change_en
);
   logic [7:0] baud_divisor_low;
   logic [3:0] baud_divisor_high;
   logic [4:0] control;
   logic [11:0] count;
   logic [3:0] tx_div;
   logic [3:0] rx_state;
   logic xck_q;
   logic tx_q;
   logic rx_q;
   logic samp_q;
   logic chg_q;
   logic [7:0] next_low;
   logic [3:0] next_high;
   logic [4:0] next_control;
   logic [11:0] next_count;
   logic [3:0] next_tx_div;
   logic [3:0] next_rx_state;
   logic next_xck;
   logic next_tx;
   logic next_rx;
   logic next_samp;
   logic next_chg;
   logic [31:0] next_prdata;
   logic [31:0] rdata_q;
   logic wr;
   logic rd;
   logic mapped;
   logic baud_tick;
   logic low_write;
   logic powered;
   logic [3:0] tx_last;
   logic [3:0] rx_last;
   logic change_edge;
   logic sample_edge;
   logic x_level;
   logic x_rise;
   logic x_fall;
   baud_clk_pkg::clk_mode_t mode;

   // ---------------------------------------------------------------
   // apb slave, zero wait state
   // ---------------------------------------------------------------
   assign pready = 1'b1;
   assign wr = psel & penable & pwrite;
   assign rd = psel & ~pwrite;
   assign mapped = (paddr == baud_clk_pkg::addr_divisor_low) |
                   (paddr == baud_clk_pkg::addr_divisor_high) |
                   (paddr == baud_clk_pkg::addr_control) |
                   (paddr == baud_clk_pkg::addr_status);
   assign pslverr = psel & penable & ~mapped;
   assign low_write = wr & (paddr == baud_clk_pkg::addr_divisor_low);
   assign prdata = rdata_q;

   // register writes in access phase, read data capture in setup phase
   always_comb begin
      next_low = baud_divisor_low;
      next_high = baud_divisor_high;
      next_control = control;
      next_prdata = rdata_q;
      if (wr && paddr == baud_clk_pkg::addr_divisor_low) begin
         next_low = pwdata[7:0];
      end
      if (wr && paddr == baud_clk_pkg::addr_divisor_high) begin
         next_high = pwdata[3:0];
      end
      if (wr && paddr == baud_clk_pkg::addr_control) begin
         next_control = pwdata[4:0];
      end
      if (rd && !penable) begin
         case (paddr)
            baud_clk_pkg::addr_divisor_low: next_prdata = {24'h000000, baud_divisor_low};
            baud_clk_pkg::addr_divisor_high: next_prdata = {28'h0000000, baud_divisor_high};
            baud_clk_pkg::addr_control: next_prdata = {27'h0000000, control};
            baud_clk_pkg::addr_status: next_prdata = {24'h000000, rx_state, x_level,
               xck_q, mode};
            default: next_prdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         baud_divisor_low <= 8'h00;
         baud_divisor_high <= 4'h0;
         control <= baud_clk_pkg::ctl_reset;
         rdata_q <= 32'h00000000;
      end else begin
         baud_divisor_low <= next_low;
         baud_divisor_high <= next_high;
         control <= next_control;
         rdata_q <= next_prdata;
      end
   end

   // ---------------------------------------------------------------
   // mode decode
   // ---------------------------------------------------------------
   assign powered = ~control[baud_clk_pkg::ctl_power_reduce];
   always_comb begin
      if (!control[baud_clk_pkg::ctl_sync_mode]) begin
         // double speed honoured only here
         mode = control[baud_clk_pkg::ctl_double_speed] ?
            baud_clk_pkg::mode_async_double : baud_clk_pkg::mode_async;
      end else if (control[baud_clk_pkg::ctl_clk_dir]) begin
         mode = baud_clk_pkg::mode_sync_master;
      end else begin
         mode = baud_clk_pkg::mode_sync_slave;
      end
   end

   always_comb begin
      case (mode)
         baud_clk_pkg::mode_async: tx_last = baud_clk_pkg::div_normal_last;
         baud_clk_pkg::mode_async_double: tx_last = baud_clk_pkg::div_double_last;
         baud_clk_pkg::mode_sync_master: tx_last = baud_clk_pkg::div_sync_last;
         default: tx_last = baud_clk_pkg::div_sync_last;
      endcase
   end
   assign rx_last = tx_last;   // 16, 8 or 2 states

   // ---------------------------------------------------------------
   // baud generator down-counter
   // ---------------------------------------------------------------
   assign baud_tick = powered & (count == 12'h000);
   always_comb begin
      next_count = count;
      if (!powered) begin
         next_count = {baud_divisor_high, baud_divisor_low};
      end else if (low_write) begin
         next_count = {baud_divisor_high, pwdata[7:0]};
      end else if (count == 12'h000) begin
         next_count = {baud_divisor_high, baud_divisor_low};
      end else begin
         next_count = count - 12'h001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 12'h000;
      end else begin
         count <= next_count;
      end
   end

   // ---------------------------------------------------------------
   // external clock path
   // ---------------------------------------------------------------
   edge_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din(xck_in),
      .level(x_level),
      .rise(x_rise),
      .fall(x_fall)
   );

   // ---------------------------------------------------------------
   // dividers and enables
   // ---------------------------------------------------------------
   always_comb begin
      next_tx_div = tx_div;
      next_rx_state = rx_state;
      next_xck = xck_q;
      next_tx = 1'b0;
      next_rx = 1'b0;
      // internal source only outside slave mode
      if (baud_tick && mode != baud_clk_pkg::mode_sync_slave) begin
         next_tx_div = (tx_div >= tx_last) ? 4'h0 : tx_div + 4'h1;
         next_tx = (tx_div >= tx_last);
         next_rx_state = (rx_state >= rx_last) ? 4'h0 : rx_state + 4'h1;
         next_rx = 1'b1;   // rx base clock is baud tick
         if (mode == baud_clk_pkg::mode_sync_master) begin
            next_xck = ~xck_q;   // master clock toggles every tick
            next_rx = 1'b0;
         end
      end
      if (!control[baud_clk_pkg::ctl_sync_mode]) begin
         next_xck = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_div <= 4'h0;
         rx_state <= 4'h0;
         xck_q <= 1'b0;
         tx_q <= 1'b0;
         rx_q <= 1'b0;
      end else begin
         tx_div <= next_tx_div;
         rx_state <= next_rx_state;
         xck_q <= next_xck;
         tx_q <= next_tx;
         rx_q <= next_rx;
      end
   end

   // ---------------------------------------------------------------
   // synchronous edge selection by polarity
   // ---------------------------------------------------------------
   always_comb begin
      change_edge = 1'b0;
      sample_edge = 1'b0;
      if (mode == baud_clk_pkg::mode_sync_master) begin
         change_edge = baud_tick & (xck_q == control[baud_clk_pkg::ctl_polarity]);
         sample_edge = baud_tick & (xck_q != control[baud_clk_pkg::ctl_polarity]);
      end else if (mode == baud_clk_pkg::mode_sync_slave) begin
         change_edge = control[baud_clk_pkg::ctl_polarity] ? x_fall : x_rise;
         sample_edge = control[baud_clk_pkg::ctl_polarity] ? x_rise : x_fall;
      end
      next_samp = sample_edge & powered;
      next_chg = change_edge & powered;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         samp_q <= 1'b0;
         chg_q <= 1'b0;
      end else begin
         samp_q <= next_samp;
         chg_q <= next_chg;
      end
   end

   // outputs; pin driven only in sync master
   assign xck_out = xck_q;
   assign xck_oe = control[baud_clk_pkg::ctl_sync_mode] & control[baud_clk_pkg::ctl_clk_dir];
   assign tx_clk_en = tx_q | ((mode == baud_clk_pkg::mode_sync_slave) & chg_q);
   assign rx_clk_en = rx_q;
   assign rx_recovery_active = ~control[baud_clk_pkg::ctl_sync_mode];
   assign sync_sample_en = samp_q;
   assign sync_change_en = chg_q;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_reload_on_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (powered && count == 12'h000 && !low_write && $stable(control))
      |=> count == $past({baud_divisor_high, baud_divisor_low}))
      else $error("counter did not reload at zero");
   a_low_write_reload: assert property (@(posedge pclk) disable iff (!presetn)
      (low_write && powered) |=> count[7:0] == $past(pwdata[7:0]))
      else $error("low byte write did not reload");
   a_tick_at_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (baud_tick && !low_write && {baud_divisor_high, baud_divisor_low} != 12'h000) |=> !baud_tick)
      else $error("tick repeated with nonzero divisor");
   a_pin_only_sync: assert property (@(posedge pclk) disable iff (!presetn)
      !control[baud_clk_pkg::ctl_sync_mode] |-> !xck_oe)
      else $error("pin driven in async mode");
   a_recovery_async: assert property (@(posedge pclk) disable iff (!presetn)
      (control[baud_clk_pkg::ctl_sync_mode] && $past(control[baud_clk_pkg::ctl_sync_mode]))
      |-> !rx_recovery_active && !rx_clk_en)
      else $error("recovery active in sync mode");
   a_slave_no_tick: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == baud_clk_pkg::mode_sync_slave && $past(mode == baud_clk_pkg::mode_sync_slave))
      |-> !tx_q)
      else $error("internal clock used in slave mode");
   a_slave_latency: assert property (@(posedge pclk) disable iff (!presetn)
      (x_rise && mode == baud_clk_pkg::mode_sync_slave && powered
       && !control[baud_clk_pkg::ctl_polarity] && $stable(control))
      |-> $past(xck_in, 2) && !$past(xck_in, 3))
      else $error("slave edge latency wrong");
   a_edges_apart: assert property (@(posedge pclk) disable iff (!presetn)
      !(samp_q && chg_q))
      else $error("sample and change on same edge");
   a_enable_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      (tx_q && mode != baud_clk_pkg::mode_sync_slave && powered) |=> !tx_q)
      else $error("transmit enable not single cycle");
   a_master_toggle: assert property (@(posedge pclk) disable iff (!presetn)
      (baud_tick && mode == baud_clk_pkg::mode_sync_master) |=> xck_out != $past(xck_out))
      else $error("master clock did not toggle on tick");
   a_async_rx_follow: assert property (@(posedge pclk) disable iff (!presetn)
      (baud_tick && !control[baud_clk_pkg::ctl_sync_mode]) |=> rx_clk_en)
      else $error("receiver base clock missed a tick");
   a_tx_on_tick: assert property (@(posedge pclk) disable iff (!presetn)
      tx_q |-> $past(baud_tick))
      else $error("transmit enable without baud tick");
   a_slave_tx_change: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == baud_clk_pkg::mode_sync_slave && $past(mode == baud_clk_pkg::mode_sync_slave))
      |-> tx_clk_en == chg_q)
      else $error("slave transmit enable not on change edge");
   a_oe_master: assert property (@(posedge pclk) disable iff (!presetn)
      xck_oe |-> mode == baud_clk_pkg::mode_sync_master)
      else $error("pin driven outside master mode");
endmodule

// >>> rtl/baud_clk_pkg.sv
// constants shared by the serial port clock generator
// ---------------------------------------------------------------
// ---------------------------------------------------------------
package baud_clk_pkg;
   // register byte addresses
   localparam logic [11:0] addr_divisor_low = 12'h000;
   localparam logic [11:0] addr_divisor_high = 12'h004;
   localparam logic [11:0] addr_control = 12'h008;
   localparam logic [11:0] addr_status = 12'h00c;
   // control field positions
   localparam int ctl_sync_mode = 0;
   localparam int ctl_double_speed = 1;
   localparam int ctl_polarity = 2;
   localparam int ctl_clk_dir = 3;
   localparam int ctl_power_reduce = 4;
   localparam logic [4:0] ctl_reset = 5'h10;
   // divider ratios
   localparam logic [3:0] div_normal_last = 4'hf;
   localparam logic [3:0] div_double_last = 4'h7;
   localparam logic [3:0] div_sync_last = 4'h1;
   localparam logic [3:0] div_half_normal = 4'h8;
   localparam logic [3:0] div_half_double = 4'h4;
   localparam int divisor_width = 12;
   typedef enum logic [1:0] {
      mode_async,
      mode_async_double,
      mode_sync_master,
      mode_sync_slave
   } clk_mode_t;
endpackage

// >>> rtl/edge_sync.sv
// synchroniser and edge detector for the external transfer clock
`timescale 1ns/10ps
module edge_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic din,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta;
   logic stage;
   logic last;
   logic next_meta;
   logic next_stage;
   logic next_last;

   // ---------------------------------------------------------------
   // two stage sampling then edge compare
   // ---------------------------------------------------------------
   always_comb begin
      next_meta = din;
      next_stage = meta;   // only reader of meta
      next_last = stage;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= 1'b0;
         stage <= 1'b0;
         last <= 1'b0;
      end else begin
         meta <= next_meta;
         stage <= next_stage;
         last <= next_last;
      end
   end

   // edge pulses one cycle wide
   assign level = stage;
   assign rise = stage & ~last;
   assign fall = ~stage & last;
endmodule

// >>> test/remote_clock_source.sv
// far-side serial device that drives the transfer clock for slave mode
`timescale 1ns/10ps
module remote_clock_source #(
   parameter int half = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic idle_level,
   output logic xck
);
   int cnt;
   // -----------------------------------
   // clock source
   // -----------------------------------
   // toggles every half cycles, parks at the idle level outside frames
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         xck <= 1'b0;
      end else if (!run) begin
         cnt <= 0;
         xck <= idle_level;
      end else if (cnt == half - 1) begin
         cnt <= 0;
         xck <= ~xck;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule

// >>> test/test_serial_port_clock_generator.sv
// self-checking bench for the serial port clock generator
`timescale 1ns/10ps
module test_serial_port_clock_generator;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, seed;
   logic xck_in, xck_out, xck_oe, tx_clk_en, rx_clk_en;
   logic rx_recovery_active, sync_sample_en, sync_change_en;
   logic run, pol, xin_d, xo_d, pick, mark;
   logic [2:0] sel;
   logic [11:0] dv;
   logic [32:0] rd_q[$];
   int gap_q[$];
   int gap, err_total, compares, cycles;

   serial_port_clock_generator DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .xck_in(xck_in),
      .xck_out(xck_out), .xck_oe(xck_oe), .tx_clk_en(tx_clk_en),
      .rx_clk_en(rx_clk_en), .rx_recovery_active(rx_recovery_active),
      .sync_sample_en(sync_sample_en), .sync_change_en(sync_change_en));

   remote_clock_source #(.half(4)) far_end (.pclk(pclk), .presetn(presetn),
      .run(run), .idle_level(pol), .xck(xck_in));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic check(input logic [32:0] got, input logic [32:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("counts: %0d compares, %0d mismatches", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // -----------------------------------
   // apb master
   // -----------------------------------
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [32:0] exp);
      rd_q.push_back(exp);
      apb(1'b0, a, 32'h0);
   endtask

   // -----------------------------------
   // output monitor
   // -----------------------------------
   // pick is the watched pulse, mark restarts the gap count
   assign pick = sel == 3'h0 ? tx_clk_en : sel == 3'h1 ? rx_clk_en :
      sel == 3'h2 ? sync_change_en : sel == 3'h3 ? sync_sample_en : xck_out !== xo_d;
   assign mark = (sel == 3'h2 || sel == 3'h3) ?
      (xck_in !== xin_d && xck_in === (pol ^ ~sel[0])) : pick;

   // compares the oldest note whenever a result shows up
   always @(posedge pclk) begin
      xin_d <= xck_in;
      xo_d <= xck_out;
      gap <= gap + 1;
      if (mark)
         gap <= 1;
      if (pick && gap_q.size() > 0)
         check(33'(gap), 33'(gap_q.pop_front()));
      if (psel && penable && pready && !pwrite && rd_q.size() > 0)
         check({pslverr, prdata}, rd_q.pop_front());
   end

   // hang guard
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         end_of_test();
      end
   end

   // -----------------------------------
   // one clock configuration
   // -----------------------------------
   task automatic run_cfg(input logic [4:0] ctl, input logic [11:0] d, input logic [2:0] s,
                          input int exp_gap);
      int n;
      apb(1'b1, baud_clk_pkg::addr_divisor_high, {28'h0, d[11:8]});
      apb(1'b1, baud_clk_pkg::addr_divisor_low, {24'h0, d[7:0]});
      apb(1'b1, baud_clk_pkg::addr_control, {27'h0, ctl});
      rd(baud_clk_pkg::addr_control, {28'h0, ctl});
      pol <= ctl[baud_clk_pkg::ctl_polarity];
      run <= ctl[0] && !ctl[3];
      sel <= s;
      @(posedge pclk);
      n = 0;
      while (pick !== 1'b1 && n < 9000) begin
         @(posedge pclk);
         n++;
      end
      @(negedge pclk);
      repeat (3) gap_q.push_back(exp_gap);
      while (gap_q.size() > 0 && n < 9000) begin
         @(posedge pclk);
         n++;
      end
      check(33'(gap_q.size()), 33'h0);
      gap_q.delete();
      check(33'(xck_oe), 33'(ctl[0] && ctl[3]));
      check(33'(rx_recovery_active), 33'(!ctl[0]));
      $display("test ctl %h div %h sel %0d done", ctl, d, s);
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      run = 1'b0;
      pol = 1'b0;
      sel = 3'h0;
      xin_d = 1'b0;
      xo_d = 1'b0;
      gap = 0;
      err_total = 0;
      compares = 0;
      cycles = 0;
      seed = 32'd35591;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(baud_clk_pkg::addr_control, 33'h10);
      apb(1'b1, 12'h010, 32'hffffffff);
      rd(12'h010, 33'h100000000);
      rd(baud_clk_pkg::addr_control, 33'h10);
      $display("test register access done");
      dv = 12'(rnd() % 8);
      run_cfg(5'h00, 12'h000, 3'h0, 16);
      run_cfg(5'h00, 12'h105, 3'h1, 262);
      run_cfg(5'h00, dv, 3'h0, 16 * (dv + 1));
      run_cfg(5'h02, dv, 3'h0, 8 * (dv + 1));
      run_cfg(5'h02, dv, 3'h1, dv + 1);
      run_cfg(5'h09, dv, 3'h0, 2 * (dv + 1));
      run_cfg(5'h09, dv, 3'h4, dv + 1);
      run_cfg(5'h01, dv, 3'h2, 3);
      run_cfg(5'h01, dv, 3'h3, 3);
      run_cfg(5'h05, dv, 3'h2, 3);
      run_cfg(5'h05, dv, 3'h3, 3);
      end_of_test();
   end
endmodule
